// >>> eps_array.sv
// Byte array with program, erase, block erase and bulk erase actions
`timescale 1ns/1ns
module eps_array #(
  parameter int BYTES = 512,
  parameter int BLOCK = 128
) (
  input wire logic clk_in,
  input wire eps_pkg::eps_cmd_type cmd_in,
  input wire logic [9:0] rd_idx_in,
  output logic [7:0] rd_data_out,
  output logic [7:0] nv_byte_out
);

  // One extra entry past the array holds the nonvolatile configuration byte
  logic [7:0] mem [0:BYTES];

  if (BLOCK * 4 != BYTES || BYTES + 1 > 1024) begin : g_chk
    $error("eps_array: geometry not supported");
  end

  // Factory state: array erased, configuration unprotected
  initial begin
    for (int i = 0; i < BYTES; i++) begin
      mem[i] = eps_pkg::ERASED_BYTE;
    end
    mem[BYTES] = eps_pkg::NVR_FACTORY;
  end

  // Programming can only clear bits; erasing sets them back
  always_ff @(posedge clk_in) begin
    if (cmd_in.go) begin
      case (cmd_in.mode)
        eps_pkg::MODE_PROG: mem[cmd_in.idx] <= mem[cmd_in.idx] & cmd_in.data;
        eps_pkg::MODE_BYTE_ER: mem[cmd_in.idx] <= eps_pkg::ERASED_BYTE;
        eps_pkg::MODE_BLOCK_ER: begin
          for (int i = 0; i < BYTES; i++) begin
            if (i / BLOCK == int'(cmd_in.idx) / BLOCK) begin
              mem[i] <= eps_pkg::ERASED_BYTE;
            end
          end
        end
        default: begin
          if (cmd_in.idx == eps_pkg::NVR_IDX) begin
            mem[BYTES] <= eps_pkg::ERASED_BYTE;
          end else begin
            for (int i = 0; i < BYTES; i++) begin
              mem[i] <= eps_pkg::ERASED_BYTE;
            end
          end
        end
      endcase
    end
  end

  assign rd_data_out = mem[rd_idx_in];
  assign nv_byte_out = mem[BYTES];

endmodule : eps_array

// >>> eps_pkg.sv
// Shared constants and types for the nonvolatile program/erase sequencer
package eps_pkg;

  // Register byte addresses on the bus (each register one aligned word)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] ACR_OFS = 12'h004;
  localparam logic [11:0] DIV_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00c;
  localparam logic [11:0] NVR_OFS = 12'h010;
  localparam logic [11:0] ARRAY_BASE = 12'h800;

  // Array geometry; index NVR_IDX is the nonvolatile configuration byte
  localparam int ARRAY_BYTES = 512;
  localparam int BLOCK_BYTES = 128;
  localparam logic [9:0] NVR_IDX = 10'h200;

  // Mode select encodings
  localparam logic [1:0] MODE_PROG = 2'h0;
  localparam logic [1:0] MODE_BYTE_ER = 2'h1;
  localparam logic [1:0] MODE_BLOCK_ER = 2'h2;
  localparam logic [1:0] MODE_BULK_ER = 2'h3;

  // Reset and factory values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] NVR_FACTORY = 8'hf0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Timebase: 35 us at a 4 ns clock
  localparam int TIMEBASE_NS = 35000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMEBASE_CYCLES = TIMEBASE_NS / CLK_PERIOD_NS;

  // Automatic termination lengths in timebase ticks, per mode
  localparam logic [7:0] AUTO_PROG_TICKS = 8'h0a;
  localparam logic [7:0] AUTO_BYTE_TICKS = 8'h0a;
  localparam logic [7:0] AUTO_BLOCK_TICKS = 8'h14;
  localparam logic [7:0] AUTO_BULK_TICKS = 8'h28;

  typedef struct packed {
    logic spare;
    logic rsv;
    logic off;
    logic er_hi;
    logic er_lo;
    logic lat;
    logic auto_end;
    logic hv;
  } eps_ctrl_type;

  typedef struct packed {
    logic go;
    logic [1:0] mode;
    logic [9:0] idx;
    logic [7:0] data;
  } eps_cmd_type;

  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [11:0] haddr;
  } eps_ahb_req_type;

endpackage : eps_pkg

// >>> eps_sequencer.sv
// Program/erase sequencer with AHB-Lite register slave
// Operation
// - Latch captures only writes inside array range or to config byte
// - Control writes blocked while latched until valid capture
// - Later valid writes replace captured address, data
// - Latched read returns data, captures address
// - High voltage refused without latch, capture
// - Auto timer ends cycle, clears high voltage
// - Clearing both bits clears only high voltage
// - Latch cannot clear while high voltage set
// - Mode encoding; protected block forbids operations
// - Only unprotected blocks and config byte change
// - Program clears bits, erase sets bits
// - High voltage drives pump when properly armed
// - Power down disables array; reset clears it
// - Reset clears voltage, latch, mode bits
// - Control bit 7 stores, does nothing
// - Array config read-only, loaded at reset
// - Timer counts a divided fixed timebase
// - Four 128-byte blocks, each with protect bit
`timescale 1ns/1ns
module eps_sequencer #(
  parameter logic [15:0] TB_DIV = 16'(eps_pkg::TIMEBASE_CYCLES)
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire eps_pkg::eps_ahb_req_type ahb_req_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic pump_on_out,
  output logic array_off_out
);

  typedef struct packed {
    eps_pkg::eps_ctrl_type ctrl;
    logic [9:0] lat_idx;
    logic [7:0] lat_data;
    logic addr_valid;
    logic [7:0] acr;
    logic [15:0] div;
    logic [7:0] ticks;
    logic fail;
    logic pend;
    logic pw;
    logic [11:0] paddr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    eps_pkg::eps_cmd_type cmd;
  } eps_state_type;

  eps_state_type s_q;
  eps_state_type s_d;

  logic tick;
  logic [7:0] rd_byte;
  logic [7:0] nv_byte;
  logic take;
  logic is_arr;
  logic is_nv;
  logic is_ee;
  logic [9:0] eidx;
  logic [7:0] target;
  logic allowed;
  logic finish;
  logic wr_ctrl;
  eps_pkg::eps_ctrl_type wc;

  if (TB_DIV == 16'h0000) begin : g_chk
    $error("eps_sequencer: TB_DIV must be nonzero");
  end

  // Fixed timebase runs only during an automatic cycle
  eps_timebase #(
    .W(16)
  ) u_timebase (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(s_q.ctrl.hv & s_q.ctrl.auto_end),
    .div_in(s_q.div),
    .tick_out(tick)
  );

  eps_array #(
    .BYTES(eps_pkg::ARRAY_BYTES),
    .BLOCK(eps_pkg::BLOCK_BYTES)
  ) u_array (
    .clk_in(clk_in),
    .cmd_in(s_q.cmd),
    .rd_idx_in(eidx),
    .rd_data_out(rd_byte),
    .nv_byte_out(nv_byte)
  );

  // Decode of the data-phase address; array words sit above ARRAY_BASE
  always_comb begin
    is_arr = s_q.paddr >= eps_pkg::ARRAY_BASE;
    is_nv = s_q.paddr == eps_pkg::NVR_OFS;
    is_ee = is_arr | is_nv;
    eidx = is_nv ? eps_pkg::NVR_IDX : {1'b0, s_q.paddr[10:2]};
  end

  // Auto length follows the selected mode
  always_comb begin
    case ({s_q.ctrl.er_hi, s_q.ctrl.er_lo})
      eps_pkg::MODE_PROG: target = eps_pkg::AUTO_PROG_TICKS;
      eps_pkg::MODE_BYTE_ER: target = eps_pkg::AUTO_BYTE_TICKS;
      eps_pkg::MODE_BLOCK_ER: target = eps_pkg::AUTO_BLOCK_TICKS;
      default: target = eps_pkg::AUTO_BULK_TICKS;
    endcase
  end

  // Protection: config byte always open; bulk needs every block open, others only the target block
  always_comb begin
    if (s_q.lat_idx == eps_pkg::NVR_IDX) begin
      allowed = 1'b1;
    end else if ({s_q.ctrl.er_hi, s_q.ctrl.er_lo} == eps_pkg::MODE_BULK_ER) begin
      allowed = s_q.acr[3:0] == 4'h0;
    end else begin
      allowed = !s_q.acr[s_q.lat_idx[8:7]];
    end
  end

  // Main next-state logic
  always_comb begin
    s_d = s_q;
    s_d.cmd.go = 1'b0;
    s_d.resp = 1'b0;
    finish = 1'b0;
    wr_ctrl = 1'b0;
    wc = eps_pkg::eps_ctrl_type'(hwdata_in[7:0]);
    take = ahb_req_in.hsel & ahb_req_in.htrans[1] & hready_in;

    // Automatic termination counts timebase ticks
    if (s_q.ctrl.hv && s_q.ctrl.auto_end && tick) begin
      s_d.ticks = s_q.ticks + 8'h01;
      if (s_q.ticks + 8'h01 >= target) begin
        s_d.ctrl.hv = 1'b0;
        finish = 1'b1;
      end
    end

    // Data phase: one wait state, then the access completes
    if (s_q.pend) begin
      s_d.pend = 1'b0;
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (s_q.pw) begin
        if (s_q.paddr == eps_pkg::CTRL_OFS) begin
          // Ignored while latched and nothing captured yet
          if (!(s_q.ctrl.lat && !s_q.addr_valid)) begin
            wr_ctrl = 1'b1;
            s_d.ctrl.spare = wc.spare;
            s_d.ctrl.off = wc.off;
            s_d.ctrl.er_hi = wc.er_hi;
            s_d.ctrl.er_lo = wc.er_lo;
            s_d.ctrl.auto_end = wc.auto_end;
            s_d.ctrl.hv = wc.hv & s_q.ctrl.lat & s_q.addr_valid;
            // Latch survives while voltage is still on
            s_d.ctrl.lat = wc.lat | s_q.ctrl.hv;
            if (s_d.ctrl.hv && !s_q.ctrl.hv) begin
              s_d.fail = 1'b0;
              s_d.ticks = 8'h00;
            end
            if (s_q.ctrl.hv && !s_d.ctrl.hv) begin
              finish = 1'b1;
            end
            if (!s_d.ctrl.lat) begin
              s_d.addr_valid = 1'b0;
            end
          end
        end else if (s_q.paddr == eps_pkg::DIV_OFS) begin
          // Divisor locked while a sequence is armed
          if (!s_q.ctrl.lat) begin
            s_d.div = hwdata_in[15:0];
          end
        end else if (is_ee && s_q.ctrl.lat && !s_q.ctrl.hv) begin
          s_d.lat_idx = eidx;
          s_d.lat_data = hwdata_in[7:0];
          s_d.addr_valid = 1'b1;
        end
      end else begin
        if (s_q.paddr == eps_pkg::CTRL_OFS) begin
          s_d.rdata = {24'h000000, s_q.ctrl};
        end else if (s_q.paddr == eps_pkg::ACR_OFS) begin
          s_d.rdata = {24'h000000, s_q.acr};
        end else if (s_q.paddr == eps_pkg::DIV_OFS) begin
          s_d.rdata = {16'h0000, s_q.div};
        end else if (s_q.paddr == eps_pkg::STAT_OFS) begin
          s_d.rdata = {29'h0, s_q.ctrl.hv & s_q.ctrl.auto_end, s_q.addr_valid, s_q.fail};
        end else if (is_ee) begin
          if (s_q.ctrl.off) begin
            s_d.rdata = 32'h0000_0000;
          end else if (s_q.ctrl.hv) begin
            // A read under high voltage spoils the cycle
            s_d.fail = 1'b1;
            s_d.rdata = {24'h000000, s_q.lat_data};
          end else if (s_q.ctrl.lat) begin
            s_d.rdata = {24'h000000, s_q.lat_data};
            s_d.lat_idx = eidx;
            s_d.addr_valid = 1'b1;
          end else begin
            s_d.rdata = {24'h000000, rd_byte};
          end
        end
      end
    end

    // End of a cycle commits the change unless spoiled or blocked
    if (finish) begin
      s_d.cmd.go = allowed & !s_q.fail & !s_d.fail & !s_q.ctrl.off;
      s_d.cmd.mode = {s_q.ctrl.er_hi, s_q.ctrl.er_lo};
      s_d.cmd.idx = s_q.lat_idx;
      s_d.cmd.data = s_q.lat_data;
    end

    // Address phase accepted only when the bus is ready
    if (take) begin
      s_d.pend = 1'b1;
      s_d.pw = ahb_req_in.hwrite;
      s_d.paddr = {ahb_req_in.haddr[11:2], 2'b00};
      s_d.ready = 1'b0;
    end

    if (sys_rst_in) begin
      s_d = '0;
      s_d.ctrl = eps_pkg::eps_ctrl_type'(eps_pkg::CTRL_RESET);
      s_d.acr = nv_byte;
      s_d.div = TB_DIV;
      s_d.ready = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge clk_in) begin
    s_q <= s_d;
  end

  assign hrdata_out = s_q.rdata;
  assign hreadyout_out = s_q.ready;
  assign hresp_out = s_q.resp;
  assign pump_on_out = s_q.ctrl.hv;
  assign array_off_out = s_q.ctrl.off;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_hv_needs_arm: assert property (
    $rose(s_q.ctrl.hv) |-> $past(s_q.ctrl.lat) && $past(s_q.addr_valid))
    else $error("high voltage set without latch and capture");

  a_pump_only_latched: assert property (
    pump_on_out |-> s_q.ctrl.lat && s_q.addr_valid)
    else $error("pump on while not armed");

  a_latch_held_hv: assert property (
    $fell(s_q.ctrl.lat) |-> !$past(s_q.ctrl.hv))
    else $error("latch cleared under high voltage");

  a_both_clear_once: assert property (
    (wr_ctrl && s_q.ctrl.hv && !wc.hv && !wc.lat) |=> !s_q.ctrl.hv && s_q.ctrl.lat)
    else $error("joint clear did not keep latch");

  a_ctrl_locked: assert property (
    (s_q.pend && s_q.pw && s_q.paddr == eps_pkg::CTRL_OFS && s_q.ctrl.lat
      && !s_q.addr_valid) |=> $stable(s_q.ctrl))
    else $error("control changed before capture");

  a_capture_range: assert property (
    (s_q.pend && s_q.pw && !is_ee) |=> $stable(s_q.lat_idx) && $stable(s_q.lat_data))
    else $error("capture from non-array address");

  a_latched_read: assert property (
    (s_q.pend && !s_q.pw && is_ee && s_q.ctrl.lat && !s_q.ctrl.hv && !s_q.ctrl.off)
      |=> hrdata_out[7:0] == $past(s_q.lat_data) && s_q.lat_idx == $past(eidx))
    else $error("latched read wrong");

  a_auto_end: assert property (
    (s_q.ctrl.hv && s_q.ctrl.auto_end && tick && s_q.ticks + 8'h01 >= target && !wr_ctrl)
      |=> !s_q.ctrl.hv ##1 !pump_on_out)
    else $error("auto timer did not end cycle");

  a_reset_clear: assert property (
    disable iff (1'b0) sys_rst_in |=> !s_q.ctrl.hv && !s_q.ctrl.lat && !s_q.ctrl.er_hi
      && !s_q.ctrl.er_lo && !s_q.ctrl.off)
    else $error("reset left control bits set");

  a_protect_block: assert property (
    (finish && s_q.lat_idx != eps_pkg::NVR_IDX && s_q.acr[s_q.lat_idx[8:7]]) |=> !s_q.cmd.go)
    else $error("operation on protected block");

  a_protect_bulk: assert property (
    (finish && {s_q.ctrl.er_hi, s_q.ctrl.er_lo} == eps_pkg::MODE_BULK_ER
      && s_q.lat_idx != eps_pkg::NVR_IDX && s_q.acr[3:0] != 4'h0) |=> !s_q.cmd.go)
    else $error("bulk erase with a protected block");

  a_capture_latest: assert property (
    (s_q.pend && s_q.pw && is_ee && s_q.ctrl.lat && !s_q.ctrl.hv)
      |=> s_q.lat_idx == $past(eidx) && s_q.lat_data == $past(hwdata_in[7:0]))
    else $error("latest array write not captured");

  a_valid_needs_latch: assert property (
    !s_q.ctrl.lat |-> !s_q.addr_valid)
    else $error("capture kept without latch");

  a_commit_target: assert property (
    finish |=> s_q.cmd.idx == $past(s_q.lat_idx)
      && s_q.cmd.mode == $past({s_q.ctrl.er_hi, s_q.ctrl.er_lo}))
    else $error("committed target or mode wrong");

  a_manual_hold: assert property (
    (s_q.ctrl.hv && !s_q.ctrl.auto_end && !wr_ctrl) |=> s_q.ctrl.hv)
    else $error("manual high voltage dropped without software");

  a_off_reads_zero: assert property (
    (s_q.pend && !s_q.pw && is_ee && s_q.ctrl.off) |=> hrdata_out == 32'h0000_0000)
    else $error("array read while powered down not zero");

  a_spare_stored: assert property (
    wr_ctrl |=> s_q.ctrl.spare == $past(wc.spare))
    else $error("spare control bit not stored");

  a_acr_read_only: assert property (
    (s_q.pend && s_q.pw && s_q.paddr == eps_pkg::ACR_OFS) |=> $stable(s_q.acr))
    else $error("array config changed by write");

  a_acr_load: assert property (
    disable iff (1'b0) sys_rst_in |=> s_q.acr == $past(nv_byte))
    else $error("array config not loaded at reset");

  a_tick_only_auto: assert property (
    tick |-> $past(s_q.ctrl.hv) && $past(s_q.ctrl.auto_end))
    else $error("timebase tick outside automatic cycle");

endmodule : eps_sequencer

// >>> eps_sequencer_tb_top.sv
// Self-checking bench for the program/erase sequencer and its register slave
`timescale 1ns/1ns
module eps_sequencer_tb_top;
  localparam logic [11:0] CTRL = eps_pkg::CTRL_OFS;
  localparam logic [11:0] STAT = eps_pkg::STAT_OFS;
  localparam logic [11:0] NVR = eps_pkg::NVR_OFS;
  // Software waits for manual cycles, in clocks; the design does not time them itself
  localparam int PGM_WAIT = 40;
  localparam int ERASE_WAIT = 40;
  localparam int FALL_WAIT = 8;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic off;
  } eps_row_type;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  eps_pkg::eps_ahb_req_type req = '0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hresp;
  logic pump;
  logic off;
  int errors = 0;
  int checked = 0;
  // Register writes then readbacks; bit 6 of control always reads back 0
  eps_row_type rows [8] = '{
    '{CTRL, 32'hc0, 32'h80, 1'b0},
    '{CTRL, 32'h20, 32'h20, 1'b1},
    '{eps_pkg::ARRAY_BASE, 32'h00, 32'h00, 1'b1},
    '{CTRL, 32'h18, 32'h18, 1'b0},
    '{CTRL, 32'h01, 32'h00, 1'b0},
    '{eps_pkg::ACR_OFS, 32'h0f, 32'hf0, 1'b0},
    '{12'h0f0, 32'h55, 32'h00, 1'b0},
    '{eps_pkg::DIV_OFS, 32'h04, 32'h04, 1'b0}};

  // Short divisor keeps every automatic cycle to at most 160 clocks (bulk erase)
  eps_sequencer #(.TB_DIV(16'h0004)) dut_u (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ahb_req_in(req),
    .hready_in(hready),
    .hwdata_in(hwdata),
    .hrdata_out(hrdata),
    .hreadyout_out(hready),
    .hresp_out(hresp),
    .pump_on_out(pump),
    .array_off_out(off)
  );

  // Free-running 250 MHz clock
  always #2 clk_in = ~clk_in;

  task end_sim;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk

  // One single transfer; both phases wait on ready with a bound
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    req <= '{1'b1, 2'h2, w, 3'h2, a};
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 50);
    req <= '0;
    hwdata <= wd;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      chk("bus ready", 32'h1, 32'h0);
      end_sim();
    end
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask : rc

  function automatic logic [11:0] aa(input int i);
    return eps_pkg::ARRAY_BASE + 12'(4 * i);
  endfunction : aa

  task rst;
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask : rst

  // Automatic-mode operation: arm, load target, apply, poll, release latch
  task op(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wr(CTRL, {27'h0, m, 3'h6});
    wr(a, {24'h0, d});
    wr(CTRL, {27'h0, m, 3'h7});
    rc("auto running", STAT, 32'h6);
    do begin
      xfer(CTRL, 1'b0, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    chk("auto hv clear", 32'h0, {31'h0, rd[0]});
    if (rd[0] !== 1'b0) begin
      end_sim();
    end
    wr(CTRL, 32'h0);
  endtask : op

  initial begin
    rst();
    rc("ctrl reset", CTRL, 32'h0);
    rc("acr reset", eps_pkg::ACR_OFS, 32'hf0);
    chk("off reset", 32'h0, {31'h0, off});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rc("row read", rows[i].a, rows[i].e);
      chk("row off", {31'h0, rows[i].off}, {31'h0, off});
      chk("row pump", 32'h0, {31'h0, pump});
    end
    // Manual program with refused control writes and repeated captures
    wr(CTRL, 32'h04);
    wr(CTRL, 32'h05);
    rc("ctrl before capture", CTRL, 32'h04);
    wr(12'h0f0, 32'h00);
    rc("no capture", STAT, 32'h0);
    wr(aa(3), 32'h5a);
    wr(aa(5), 32'ha5);
    rc("latched read", aa(7), 32'ha5);
    wr(CTRL, 32'h05);
    chk("pump on", 32'h1, {31'h0, pump});
    repeat (PGM_WAIT) @(posedge clk_in);
    wr(CTRL, 32'h01);
    rc("latch kept", CTRL, 32'h05);
    wr(CTRL, 32'h00);
    rc("hv only cleared", CTRL, 32'h04);
    chk("pump off", 32'h0, {31'h0, pump});
    repeat (FALL_WAIT) @(posedge clk_in);
    wr(CTRL, 32'h00);
    rc("read target", aa(7), 32'ha5);
    rc("old target", aa(5), 32'hff);
    rc("first target", aa(3), 32'hff);
    // Automatic program then byte and block erase
    op(eps_pkg::MODE_PROG, aa(7), 8'h0f);
    rc("program and", aa(7), 32'h05);
    op(eps_pkg::MODE_BYTE_ER, aa(7), 8'h00);
    rc("byte erase", aa(7), 32'hff);
    op(eps_pkg::MODE_PROG, aa(130), 8'h00);
    op(eps_pkg::MODE_PROG, aa(300), 8'h11);
    op(eps_pkg::MODE_BLOCK_ER, aa(129), 8'h33);
    rc("block erased", aa(130), 32'hff);
    rc("other block", aa(300), 32'h11);
    // Array read while the pump is on spoils the cycle
    wr(CTRL, 32'h04);
    wr(aa(20), 32'h00);
    wr(CTRL, 32'h05);
    xfer(aa(20), 1'b0, 32'h0);
    wr(CTRL, 32'h04);
    wr(CTRL, 32'h00);
    xfer(STAT, 1'b0, 32'h0);
    chk("fail flag", 32'h1, {31'h0, rd[0]});
    rc("spoiled cycle", aa(20), 32'hff);
    // Protect block 2 through the config byte, seen after reset
    op(eps_pkg::MODE_BYTE_ER, NVR, 8'h00);
    op(eps_pkg::MODE_PROG, NVR, 8'hf4);
    wr(CTRL, 32'h20);
    rst();
    chk("off cleared", 32'h0, {31'h0, off});
    rc("acr loaded", eps_pkg::ACR_OFS, 32'hf4);
    op(eps_pkg::MODE_PROG, aa(300), 8'h00);
    rc("protected", aa(300), 32'h11);
    op(eps_pkg::MODE_PROG, aa(10), 8'h00);
    rc("unprotected", aa(10), 32'h00);
    op(eps_pkg::MODE_BULK_ER, aa(0), 8'h00);
    rc("bulk refused", aa(10), 32'h00);
    // Lift protection, then bulk erase the whole array
    op(eps_pkg::MODE_BYTE_ER, NVR, 8'h00);
    op(eps_pkg::MODE_PROG, NVR, 8'hf0);
    rst();
    op(eps_pkg::MODE_BULK_ER, aa(511), 8'h00);
    rc("bulk low", aa(10), 32'hff);
    rc("bulk high", aa(300), 32'hff);
    // Manual byte erase of a freshly programmed byte
    op(eps_pkg::MODE_PROG, aa(40), 8'h00);
    rc("before erase", aa(40), 32'h00);
    wr(CTRL, 32'h0c);
    wr(aa(40), 32'h00);
    wr(CTRL, 32'h0d);
    repeat (ERASE_WAIT) @(posedge clk_in);
    wr(CTRL, 32'h0c);
    repeat (FALL_WAIT) @(posedge clk_in);
    wr(CTRL, 32'h00);
    rc("manual erase", aa(40), 32'hff);
    chk("resp okay", 32'h0, {31'h0, hresp});
    end_sim();
  end
endmodule : eps_sequencer_tb_top

// >>> eps_timebase.sv
// Timebase divider producing a one-cycle tick every divisor clocks
`timescale 1ns/1ns
module eps_timebase #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire logic [W-1:0] div_in,
  output logic tick_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } eps_tb_state_type;

  eps_tb_state_type s_q;
  eps_tb_state_type s_d;

  if (W < 2) begin : g_chk
    $error("eps_timebase: W too small");
  end

  // Counter restarts whenever the cycle is not running, so each cycle starts aligned
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (sys_rst_in || !run_in) begin
      s_d.cnt = '0;
    end else if (s_q.cnt + W'(1) >= div_in) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    s_q <= s_d;
  end

  assign tick_out = s_q.tick;

endmodule : eps_timebase
